// [rtl/lbwrh_local_bus.v]
/*
 local bus interface: eight-region external bus with per-region wait states,
 address strobe extension, pseudo-static ram refresh and bus hold handover.
 assumes a core request port on i_ref_clk, configuration as plain inputs, and
 an outside pad ring that turns data/oe triples into two-way pins.
*/
`timescale 1ns/1ns
`include "lbwrh_regs.vh"

// Overview of operation
// - addresses reach a full 1M-byte external space
// - memory grows in 64K-byte banks
// - eight regions, each with own wait/refresh
// - per-region wait states during read/write strobe
// - global option stretches address strobe period
// - periodic refresh bus cycle pulses refresh pin
// - refresh pulses overlap accesses to chosen regions
// - standby holds refresh pin low
// - hold request: finish cycle, float, acknowledge
// - no wait or refresh while held
module lbwrh_local_bus #(
   parameter ADDR_W = `LBWRH_ADDR_W,
   parameter WAIT_W = `LBWRH_WAIT_W,
   parameter REF_W = 16,
   parameter PULSE_CYC = `LBWRH_REFRESH_PULSE_CYC
) (
   input wire i_ref_clk,
   input wire i_rst,
   input wire i_req,
   input wire i_req_write,
   input wire [ADDR_W-1:0] i_req_addr,
   input wire [7:0] i_req_wdata,
   output reg o_req_done,
   output reg [7:0] o_req_rdata,
   output reg o_busy,
   input wire [8*WAIT_W-1:0] i_cfg_region_wait,
   input wire i_cfg_address_wait,
   input wire i_cfg_refresh_en,
   input wire [REF_W-1:0] i_cfg_refresh_interval,
   input wire [7:0] i_cfg_refresh_area,
   input wire i_standby,
   output reg [ADDR_W-1:0] o_addr,
   output reg [7:0] o_ad_out,
   input wire [7:0] i_ad_in,
   output reg o_ad_oe,
   output reg o_ctrl_oe,
   output reg o_address_strobe,
   output reg o_rd_n,
   output reg o_wr_n,
   output reg o_refresh_request_pin_n,
   input wire i_hold_request,
   output reg o_hold_acknowledge,
   output reg [`LBWRH_NUM_REGIONS-1:0] o_region_sel
);

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function [WAIT_W-1:0] region_wait;
      input [8*WAIT_W-1:0] cfg;
      input [2:0] region;
      begin
         region_wait = cfg[region*WAIT_W +: WAIT_W];
      end
   endfunction

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   reg hold_meta;
   reg hold_sync;
   reg [7:0] ad_meta;
   reg [7:0] ad_sync;
   always @(posedge i_ref_clk) begin
      if (i_rst) begin
         hold_meta <= 1'b0;
         hold_sync <= 1'b0;
         ad_meta <= 8'h00;
         ad_sync <= 8'h00;
      end else begin
         hold_meta <= i_hold_request;
         hold_sync <= hold_meta;
         ad_meta <= i_ad_in;
         ad_sync <= ad_meta;
      end
   end

   // ----------------------------------------
   // refresh interval timer
   // ----------------------------------------
   reg [REF_W-1:0] ref_cnt;
   reg ref_due;
   reg [2:0] state;
   // binary state codes
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_ADDR = 3'h1;
   localparam [2:0] ST_STROBE = 3'h2;
   localparam [2:0] ST_REFRESH = 3'h3;
   localparam [2:0] ST_HOLD = 3'h4;
   localparam [2:0] ST_SELFREF = 3'h5;
   reg [WAIT_W:0] cnt;
   reg [7:0] pulse_cnt;
   reg cur_write;
   reg [2:0] cur_region;
   wire held = (state == ST_HOLD);
   wire ref_tick = (ref_cnt == {REF_W{1'b0}});
   // region 3-bit field selects one of eight logical spaces
   wire [2:0] req_region = i_req_addr[`LBWRH_REGION_MSB:`LBWRH_REGION_LSB];
   // a waiting access to a refresh area carries the pulse instead
   wire ride_ok = i_req && i_cfg_refresh_area[req_region];

   always @(posedge i_ref_clk) begin
      if (i_rst) begin
         ref_cnt <= `LBWRH_REFRESH_INTERVAL_RST;
         ref_due <= 1'b0;
      end else if (!i_cfg_refresh_en || held) begin
         // timer reloaded from the interval while held or disabled
         ref_cnt <= i_cfg_refresh_interval;
         ref_due <= ref_due & ~held;
      end else begin
         ref_cnt <= ref_tick ? i_cfg_refresh_interval : ref_cnt - 1'b1;
         if (ref_tick) begin
            ref_due <= 1'b1;
         end else if (pulse_cnt == 8'h01) begin
            ref_due <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // bus sequencer
   // ----------------------------------------
   always @(posedge i_ref_clk) begin
      if (i_rst) begin
         state <= ST_IDLE;
         cnt <= {(WAIT_W+1){1'b0}};
         pulse_cnt <= 8'h00;
         cur_write <= 1'b0;
         cur_region <= 3'h0;
         o_req_done <= 1'b0;
         o_req_rdata <= 8'h00;
         o_busy <= 1'b0;
         o_addr <= {ADDR_W{1'b0}};
         o_ad_out <= 8'h00;
         o_ad_oe <= 1'b0;
         o_ctrl_oe <= 1'b1;
         o_address_strobe <= 1'b0;
         o_rd_n <= 1'b1;
         o_wr_n <= 1'b1;
         o_refresh_request_pin_n <= 1'b1;
         o_hold_acknowledge <= 1'b0;
         o_region_sel <= 8'h00;
      end else begin
         o_req_done <= 1'b0;
         // a running refresh pulse ends after its fixed width, unless hold or standby is entered first
         if (pulse_cnt != 8'h00) begin
            pulse_cnt <= pulse_cnt - 8'h01;
            if (pulse_cnt == 8'h01) begin
               o_refresh_request_pin_n <= 1'b1;
            end
         end
         case (state)
            ST_IDLE: begin
               o_busy <= 1'b0;
               o_ad_oe <= 1'b0;
               if (hold_sync) begin
                  // idle means no cycle in flight; float and acknowledge in the same cycle
                  o_ctrl_oe <= 1'b0;
                  o_hold_acknowledge <= 1'b1;
                  o_refresh_request_pin_n <= 1'b1;
                  pulse_cnt <= 8'h00;
                  o_busy <= 1'b1;
                  state <= ST_HOLD;
               end else if (i_standby) begin
                  o_refresh_request_pin_n <= 1'b0;
                  pulse_cnt <= 8'h00;
                  o_busy <= 1'b1;
                  state <= ST_SELFREF;
               end else if (ref_due && pulse_cnt == 8'h00 && !ride_ok) begin
                  // dedicated refresh cycle, unless an access can carry it
                  o_refresh_request_pin_n <= 1'b0;
                  pulse_cnt <= PULSE_CYC[7:0];
                  o_busy <= 1'b1;
                  state <= ST_REFRESH;
               end else if (i_req) begin
                  // full 20-bit address, 64K banks sit at bit 16 upward
                  o_addr <= i_req_addr;
                  o_ad_out <= i_req_wdata;
                  o_ad_oe <= 1'b1;
                  cur_write <= i_req_write;
                  cur_region <= req_region;
                  o_region_sel <= 8'h01 << req_region;
                  o_address_strobe <= 1'b1;
                  o_busy <= 1'b1;
                  // one extra strobe cycle gives the decoder more time
                  cnt <= i_cfg_address_wait ? {{WAIT_W{1'b0}}, 1'b1} : {(WAIT_W+1){1'b0}};
                  // refresh rides along with an access to a chosen region
                  if (ref_due && i_cfg_refresh_area[req_region] && pulse_cnt == 8'h00) begin
                     o_refresh_request_pin_n <= 1'b0;
                     pulse_cnt <= PULSE_CYC[7:0];
                  end
                  state <= ST_ADDR;
               end
            end
            ST_ADDR: begin
               if (cnt != {(WAIT_W+1){1'b0}}) begin
                  cnt <= cnt - 1'b1;
               end else begin
                  o_address_strobe <= 1'b0;
                  o_ad_oe <= cur_write;
                  o_rd_n <= cur_write;
                  o_wr_n <= ~cur_write;
                  // per-region wait while strobe active, from config inputs
                  cnt <= {1'b0, region_wait(i_cfg_region_wait, cur_region)};
                  state <= ST_STROBE;
               end
            end
            ST_STROBE: begin
               if (cnt != {(WAIT_W+1){1'b0}}) begin
                  cnt <= cnt - 1'b1;
               end else begin
                  // cycle completes before any hold is honoured
                  o_rd_n <= 1'b1;
                  o_wr_n <= 1'b1;
                  o_ad_oe <= 1'b0;
                  o_region_sel <= 8'h00;
                  o_req_rdata <= cur_write ? o_req_rdata : ad_sync;
                  o_req_done <= 1'b1;
                  state <= ST_IDLE;
               end
            end
            ST_REFRESH: begin
               if (pulse_cnt == 8'h01) begin
                  state <= ST_IDLE;
               end
            end
            ST_HOLD: begin
               // no wait or refresh activity while the bus is lent out
               o_busy <= 1'b1;
               if (!hold_sync) begin
                  // external master keeps request up while it owns the bus
                  o_hold_acknowledge <= 1'b0;
                  o_ctrl_oe <= 1'b1;
                  state <= ST_IDLE;
               end
            end
            ST_SELFREF: begin
               // level held, not pulsed, so the ram self-refreshes
               o_busy <= 1'b1;
               o_refresh_request_pin_n <= ~i_standby;
               if (!i_standby) begin
                  state <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

endmodule // lbwrh_local_bus

// [rtl/lbwrh_regs.vh]
/*
 local bus wait/refresh/hold constants: address layout, timing counts.
 assumes a 250 MHz system clock; included by the bus interface module only.
*/
`ifndef LBWRH_REGS_VH
`define LBWRH_REGS_VH

// ----------------------------------------
// address space layout
// ----------------------------------------
`define LBWRH_ADDR_W 20
`define LBWRH_REGION_MSB 19
`define LBWRH_REGION_LSB 17
`define LBWRH_NUM_REGIONS 8
`define LBWRH_BANK_LSB 16
`define LBWRH_WAIT_W 3

// ----------------------------------------
// timing and reset values
// ----------------------------------------
`define LBWRH_CLK_MHZ 250
`define LBWRH_REFRESH_PULSE_NS 16
`define LBWRH_REFRESH_PULSE_CYC ((`LBWRH_REFRESH_PULSE_NS * `LBWRH_CLK_MHZ + 999) / 1000)
`define LBWRH_REFRESH_INTERVAL_RST 16'h0100

`endif

// [sim/lbwrh_checker.sv]
/* checker: bus, refresh and hold timing at the local bus pins.
   assumes binding into lbwrh_local_bus; sees its ports only. */
`timescale 1ns/1ns
module lbwrh_checker #(parameter PULSE_CYC = 4) (
   input wire i_ref_clk,
   input wire i_rst,
   input wire i_cfg_address_wait,
   input wire i_standby,
   input wire i_hold_request,
   input wire o_req_done,
   input wire o_busy,
   input wire [19:0] o_addr,
   input wire o_ad_oe,
   input wire o_ctrl_oe,
   input wire o_address_strobe,
   input wire o_rd_n,
   input wire o_wr_n,
   input wire o_refresh_request_pin_n,
   input wire o_hold_acknowledge,
   input wire [7:0] o_region_sel
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   // repetition needs a literal, so the default pulse width is spelt out
   sequence s_pulse; !o_refresh_request_pin_n [*4] ##1 o_refresh_request_pin_n; endsequence
   sequence s_ext; o_address_strobe ##1 !o_address_strobe; endsequence
   AST_DONE_ONE: assert property (o_req_done |=> !o_req_done)
      else $error("done held");
   AST_ADDRESS_STROBE_BASE: assert property (
      $rose(o_address_strobe) && !i_cfg_address_wait |=> !o_address_strobe) else $error("address_strobe");
   AST_ADDRESS_STROBE_EXT: assert property (
      $rose(o_address_strobe) && i_cfg_address_wait |=> s_ext) else $error("address_strobe ext");
   AST_REGION: assert property (
      o_address_strobe |-> o_ctrl_oe && o_region_sel == (8'h01 << o_addr[19:17])) else $error("region");
   AST_RD_ALONE: assert property (!o_rd_n |-> o_wr_n && !o_ad_oe && !o_address_strobe)
      else $error("read overlap");
   AST_PULSE: assert property ($fell(o_refresh_request_pin_n) && !i_standby |-> s_pulse)
      else $error("pulse width");
   AST_SELFREF: assert property (i_standby && !o_refresh_request_pin_n |=> !o_refresh_request_pin_n)
      else $error("self refresh");
   AST_HOLD_FLOAT: assert property (
      o_hold_acknowledge |-> !o_ctrl_oe && !o_ad_oe && o_refresh_request_pin_n) else $error("hold");
   AST_HOLD_AFTER: assert property ($rose(o_hold_acknowledge) |-> $past(o_rd_n) && $past(o_wr_n))
      else $error("hold early");
   AST_HOLD_LAT: assert property ($rose(i_hold_request) |-> ##[1:24] o_hold_acknowledge)
      else $error("hold late");
   AST_BUSY: assert property (
      o_address_strobe || !o_rd_n || !o_wr_n || o_hold_acknowledge |-> o_busy) else $error("busy low");
endmodule // lbwrh_checker
bind lbwrh_local_bus lbwrh_checker #(.PULSE_CYC(PULSE_CYC)) lbwrh_checker_inst (.*);

// [sim/lbwrh_mem.sv]
/* partner: byte memory on the multiplexed local bus.
   assumes device-driven strobes; floats to inverted last data when unread. */
`timescale 1ns/1ns
module lbwrh_mem (
   input wire i_ref_clk,
   input wire [19:0] i_addr,
   input wire [7:0] i_ad,
   input wire i_rd_n,
   input wire i_wr_n,
   output reg [7:0] o_ad
);
   reg [7:0] mem [0:255];
   reg [7:0] last = 8'h00;
   wire [7:0] idx = {i_addr[19:17], i_addr[4:0]};
   always @(posedge i_ref_clk) begin
      if (!i_wr_n) mem[idx] <= i_ad;
      if (!i_rd_n) last <= mem[idx];
   end
   // released bus shows inverse, not a stale match
   always @* o_ad = i_rd_n ? ~last : mem[idx];
endmodule // lbwrh_mem

// [sim/local_bus_wait_refresh_hold_tb.sv]
/* testbench: region waits, address wait, refresh, hold and standby.
   assumes lbwrh_local_bus at 250 MHz with default parameters. */
`timescale 1ns/1ns
module local_bus_wait_refresh_hold_tb;
   logic i_ref_clk = 1'h0, i_rst = 1'h1, i_req = 1'h0, i_req_write = 1'h0, i_standby = 1'h0;
   logic i_cfg_address_wait = 1'h0, i_cfg_refresh_en = 1'h1, i_hold_request = 1'h0, ref_prev = 1'h1;
   logic [19:0] i_req_addr = 20'h0, a;
   logic [7:0] i_req_wdata = 8'h0, i_cfg_refresh_area = 8'ha5, r = 8'h58, act_cyc = 8'h0;
   logic [7:0] ref_cnt = 8'h0, ride_cnt = 8'h0, n0, shadow [0:255];
   logic [23:0] i_cfg_region_wait = {3'h7, 3'h2, 3'h5, 3'h0, 3'h3, 3'h6, 3'h4, 3'h1};
   logic [15:0] i_cfg_refresh_interval = 16'h0040;
   logic [12:0] e, exp_q[$];
   wire o_req_done, o_busy, o_ad_oe, o_ctrl_oe, o_address_strobe, o_rd_n, o_wr_n;
   wire o_refresh_request_pin_n, o_hold_acknowledge;
   wire [19:0] o_addr;
   wire [7:0] o_req_rdata, o_ad_out, i_ad_in, o_region_sel;
   int err_count = 0, comparisons = 0, cyc = 0, k;
   lbwrh_local_bus lbwrh_local_bus_inst (.*);
   lbwrh_mem lbwrh_mem_inst (.i_ref_clk(i_ref_clk), .i_addr(o_addr), .i_ad(o_ad_out),
      .i_rd_n(o_rd_n), .i_wr_n(o_wr_n), .o_ad(i_ad_in));
   always #2 i_ref_clk = ~i_ref_clk;
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic close_out;
      check("pending", 8'(exp_q.size()), 8'h00);
      if (err_count == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // note expectation, hold request until done, drop it in the done cycle
   task automatic access(input logic wr, input logic [19:0] ad, input logic [7:0] d);
      logic [2:0] w;
      int n;
      @(negedge i_ref_clk);
      w = i_cfg_region_wait[3*ad[19:17] +: 3];
      exp_q.push_back({!wr, 4'(w + 4'h2 + i_cfg_address_wait), wr ? d : shadow[{ad[19:17], ad[4:0]}]});
      if (wr) shadow[{ad[19:17], ad[4:0]}] = d;
      i_req_write = wr;
      i_req_addr = ad;
      i_req_wdata = d;
      i_req = 1'h1;
      for (n = 0; n < 40 && o_req_done !== 1'h1; n++) @(negedge i_ref_clk);
      i_req = 1'h0;
   endtask
   // strobe and wait cycles counted per access, refresh pulses counted throughout
   always @(negedge i_ref_clk) begin
      if (o_address_strobe === 1'h1 || o_rd_n === 1'h0 || o_wr_n === 1'h0) act_cyc++;
      if (ref_prev === 1'h1 && o_refresh_request_pin_n === 1'h0) begin
         ref_cnt++;
         if (o_address_strobe === 1'h1) ride_cnt++;
      end
      ref_prev = o_refresh_request_pin_n;
      if (o_req_done === 1'h1) begin
         e = (exp_q.size() > 0) ? exp_q.pop_front() : 13'h1fff;
         check("cycles", act_cyc, {4'h0, e[11:8]});
         if (e[12]) check("rdata", o_req_rdata, e[7:0]);
         act_cyc = 8'h0;
      end
   end
   always @(posedge i_ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         close_out();
      end
   end
   initial begin
      repeat (5) @(posedge i_ref_clk);
      @(negedge i_ref_clk) i_rst = 1'h0;
      // every region, both address-wait settings; reads skip the two fastest regions
      for (int j = 0; j < 32; j++) begin
         r = lfsr(r);
         i_cfg_address_wait = j[4];
         a = {j[2:0], 12'h000, j[4], 4'h5};
         if (!j[3]) access(1'h1, a, r);
         else if (i_cfg_region_wait[3*j[2:0] +: 3] > 3'h1) access(1'h0, a, 8'h00);
      end
      n0 = ref_cnt;
      repeat (192) @(negedge i_ref_clk);
      check("refresh", 8'(ref_cnt - n0 >= 8'h2 && ref_cnt - n0 <= 8'h4), 8'h1);
      // line a request up with the next tick (period interval + 1) so it carries the pulse
      for (k = 0; k < 80 && o_refresh_request_pin_n !== 1'h1; k++) @(negedge i_ref_clk);
      for (k = 0; k < 80 && o_refresh_request_pin_n !== 1'h0; k++) @(negedge i_ref_clk);
      repeat (63) @(negedge i_ref_clk);
      n0 = ride_cnt;
      access(1'h1, 20'h00007, r);
      check("ride pulse", ride_cnt - n0, 8'h1);
      fork
         access(1'h0, 20'h20005, 8'h00);
         begin
            repeat (2) @(negedge i_ref_clk);
            // outside master asks mid-cycle and keeps asking while it owns the bus
            i_hold_request = 1'h1;
         end
      join
      for (k = 0; k < 40 && o_hold_acknowledge !== 1'h1; k++) @(negedge i_ref_clk);
      check("hold ack", o_hold_acknowledge, 8'h1);
      n0 = ref_cnt;
      repeat (200) @(negedge i_ref_clk);
      check("held refresh", ref_cnt - n0, 8'h0);
      check("held ctrl", o_ctrl_oe, 8'h0);
      check("held busy", o_busy, 8'h1);
      i_hold_request = 1'h0;
      for (k = 0; k < 40 && o_hold_acknowledge !== 1'h0; k++) @(negedge i_ref_clk);
      check("released ctrl", o_ctrl_oe, 8'h1);
      i_cfg_refresh_en = 1'h0;
      repeat (80) @(negedge i_ref_clk);
      i_standby = 1'h1;
      repeat (40) @(negedge i_ref_clk);
      check("standby pin", o_refresh_request_pin_n, 8'h0);
      i_standby = 1'h0;
      repeat (4) @(negedge i_ref_clk);
      check("wake pin", o_refresh_request_pin_n, 8'h1);
      access(1'h0, 20'h20005, 8'h00);
      repeat (4) @(negedge i_ref_clk);
      close_out();
   end
endmodule // local_bus_wait_refresh_hold_tb
